// ### pkg/wdg_pkg.sv
package wdg_pkg;

  // register map, byte addresses on the bus
  localparam logic [31:0] WDG_CTRL_OFS = 32'h0000_00d8;
  localparam logic [7:0] WDG_CTRL_RST = 8'hfe;

  // field positions inside the control register
  localparam int WDG_C_BIT = 0;
  localparam int WDG_SR_BIT = 1;
  localparam int WDG_T_LO_BIT = 2;
  localparam int WDG_T_HI_BIT = 7;

  // counter value after any reset: all count bits and the sr bit set
  localparam logic [6:0] WDG_CNT_RST = 7'h7f;

  // timing, oscillator cycles and nanoseconds
  localparam int WDG_CLK_PERIOD_NS = 5;
  localparam int WDG_STEP_CYC = 3072;
  localparam int WDG_TMO_MIN_CYC = 3072;
  localparam int WDG_TMO_MAX_CYC = 196608;
  localparam int WDG_STAB_NS = 20480;
  localparam int WDG_STAB_CYC =
    (WDG_STAB_NS + WDG_CLK_PERIOD_NS - 1) / WDG_CLK_PERIOD_NS;

  // axi4-lite responses
  localparam logic [1:0] WDG_RESP_OKAY = 2'h0;
  localparam logic [1:0] WDG_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WDG_RUN,
    WDG_WAIT,
    WDG_STOP,
    WDG_RST_HOLD
  } wdg_mode_t;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } wdg_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } wdg_axil_rsp_t;

endpackage : wdg_pkg

// ### hw/wdg_prescaler.sv
module wdg_prescaler import wdg_pkg::*; #(
  parameter int STEP_CYC = WDG_STEP_CYC
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // control
  input wire logic run_i,
  input wire logic clr_i,
  // one-cycle step pulse
  output logic tick_o
);

  typedef struct packed {
    logic [17:0] cnt;
  } wdg_pre_state_t;

  wdg_pre_state_t st_q;
  wdg_pre_state_t st_d;
  localparam logic [17:0] LAST = 18'(STEP_CYC - 1);

  // step pulse on the last cycle of each period while running
  assign tick_o = run_i && !clr_i && (st_q.cnt == LAST);

  // a clear restarts the period so a reload gets a full first step
  always_comb begin
    st_d = st_q;
    if (clr_i) begin
      st_d.cnt = '0;
    end else if (run_i) begin
      st_d.cnt = (st_q.cnt == LAST) ? '0 : st_q.cnt + 18'h1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : wdg_prescaler

// ### hw/wdg_axil_slave.sv
module wdg_axil_slave import wdg_pkg::*; (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // bus side
  input wire wdg_axil_req_t req_i,
  output wdg_axil_rsp_t rsp_o,
  // register side
  output logic wr_o,
  output logic [7:0] wr_data_o,
  input wire logic [7:0] rd_data_i
);

  typedef struct packed {
    logic aw_got;
    logic [31:0] aw_addr;
    logic w_got;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } wdg_bus_state_t;

  wdg_bus_state_t st_q;
  wdg_bus_state_t st_d;
  logic both;
  logic aw_hit;

  // address and data are taken in either order; response after both
  assign both = st_q.aw_got && st_q.w_got && !st_q.bvalid;
  assign aw_hit = st_q.aw_addr[31:2] == WDG_CTRL_OFS[31:2];
  assign wr_o = both && aw_hit && st_q.wstrb0;
  assign wr_data_o = st_q.wdata;

  // handshake outputs are combinational, data from flops
  always_comb begin
    rsp_o = '0;
    rsp_o.awready = !st_q.aw_got && !st_q.bvalid;
    rsp_o.wready = !st_q.w_got && !st_q.bvalid;
    rsp_o.bvalid = st_q.bvalid;
    rsp_o.bresp = st_q.bresp;
    rsp_o.arready = !st_q.rvalid;
    rsp_o.rvalid = st_q.rvalid;
    rsp_o.rdata = st_q.rdata;
    rsp_o.rresp = st_q.rresp;
  end

  always_comb begin
    st_d = st_q;
    if (req_i.awvalid && rsp_o.awready) begin
      st_d.aw_got = 1'b1;
      st_d.aw_addr = req_i.awaddr;
    end
    if (req_i.wvalid && rsp_o.wready) begin
      st_d.w_got = 1'b1;
      st_d.wdata = req_i.wdata[7:0];
      st_d.wstrb0 = req_i.wstrb[0];
    end
    if (both) begin
      st_d.aw_got = 1'b0;
      st_d.w_got = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = aw_hit ? WDG_RESP_OKAY : WDG_RESP_SLVERR;
    end else if (st_q.bvalid && req_i.bready) begin
      st_d.bvalid = 1'b0;
    end
    // unmapped reads answer zero with a slave error
    if (req_i.arvalid && rsp_o.arready) begin
      st_d.rvalid = 1'b1;
      if (req_i.araddr[31:2] == WDG_CTRL_OFS[31:2]) begin
        st_d.rdata = {24'h0, rd_data_i};
        st_d.rresp = WDG_RESP_OKAY;
      end else begin
        st_d.rdata = '0;
        st_d.rresp = WDG_RESP_SLVERR;
      end
    end else if (st_q.rvalid && req_i.rready) begin
      st_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : wdg_axil_slave

// ### hw/wdg_top.sv
// Contract
// - active counter runs out, chip reset follows
// - software option: inactive until activation bit set
// - once active, only chip reset deactivates
// - inactive watchdog allows genuine stop mode
// - hardware option without gating: stop acts wait
// - gated stop with nmi low acts wait
// - gated stop with nmi high freezes counter
// - leaving stop resumes count from held value
// - reset loads control register with fe
// - sr bit written to zero resets immediately; here only when sr was one, in run or wait mode
// - count bits reversed: bit7 lsb, bit2 msb
// - reset when counter bit six falls
// - sixty four periods, 3072 to 196608 cycles
// - watchdog reset holds for stabilisation delay
// - hardware option reads activation bit one
// - inactive counter is free 7-bit timer
// - internal reset drives reset pin low
module wdg_top import wdg_pkg::*; #(
  parameter int STEP_CYC = WDG_STEP_CYC,
  parameter int STAB_CYC = WDG_STAB_CYC
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // register bus
  input wire wdg_axil_req_t axil_req_i,
  output wdg_axil_rsp_t axil_rsp_o,
  // option straps, held steady while running
  input wire logic hw_activation_opt_i,
  input wire logic ext_stop_opt_i,
  // processor core
  input wire logic nmi_pin_i,
  input wire logic stop_req_i,
  input wire logic wake_i,
  output logic wait_mode_o,
  output logic stop_mode_o,
  output logic wdg_active_o,
  // chip reset logic and reset pin (open drain)
  output logic chip_reset_o,
  output logic reset_pin_o,
  output logic reset_pin_oe_o
);

  typedef struct packed {
    logic [6:0] cnt;
    logic ctrl_c;
    wdg_mode_t mode;
    logic [15:0] hold;
  } wdg_state_t;

  wdg_state_t st_q;
  wdg_state_t st_d;
  logic wr;
  logic [7:0] wr_data;
  logic [7:0] rd_val;
  logic [6:0] wr_cnt;
  logic [6:0] dec_cnt;
  logic tick;
  logic run;
  logic active;
  logic trig;
  logic trig_sr;
  logic trig_tmo;

  // hold length is a parameter so the start-up delay can be matched
  localparam logic [15:0] HOLD_LAST = 16'(STAB_CYC - 1);

  // bus slave for the single control register
  wdg_axil_slave u_bus (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .req_i(axil_req_i),
    .rsp_o(axil_rsp_o),
    .wr_o(wr),
    .wr_data_o(wr_data),
    .rd_data_i(rd_val)
  );

  // counter stands still in true stop and while the chip is held
  assign run = (st_q.mode == WDG_RUN) || (st_q.mode == WDG_WAIT);

  // fixed step prescaler, restarted by every reload
  wdg_prescaler #(
    .STEP_CYC(STEP_CYC)
  ) u_pre (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .run_i(run),
    .clr_i(wr),
    .tick_o(tick)
  );

  // activation is the sticky bit or the hardware strap
  assign active = st_q.ctrl_c || hw_activation_opt_i;

  // register bits map reversed onto the physical counter
  assign rd_val[WDG_C_BIT] = active;
  assign rd_val[WDG_SR_BIT] = st_q.cnt[6];
  assign wr_cnt[6] = wr_data[WDG_SR_BIT];
  for (genvar i = 0; i < 6; i++) begin : g_map
    assign rd_val[WDG_T_HI_BIT - i] = st_q.cnt[i];
    assign wr_cnt[i] = wr_data[WDG_T_HI_BIT - i];
  end

  // a wrap from 00 to 7f is harmless: bit six rises, never falls
  assign dec_cnt = st_q.cnt - 7'h1;

  // sr written from one to zero resets at once in run or wait mode, not in stop or hold
  assign trig_sr = wr && run && st_q.cnt[6] && !wr_cnt[6];
  // bit six falling on a step is the end of count when active;
  // the reload wins when it lands on the same edge as a step
  assign trig_tmo = !wr && tick && active && st_q.cnt[6] &&
    !dec_cnt[6];
  assign trig = trig_sr || trig_tmo;

  // mode, counter and hold sequencing
  always_comb begin
    st_d = st_q;
    unique case (st_q.mode)
      WDG_RST_HOLD: begin
        // counter and control sit at reset value while held
        if (st_q.hold == HOLD_LAST) begin
          st_d.mode = WDG_RUN;
          st_d.hold = '0;
        end else begin
          st_d.hold = st_q.hold + 16'h1;
        end
      end
      WDG_STOP: begin
        // counter frozen; an interrupt resumes counting from here
        if (wake_i) begin
          st_d.mode = WDG_RUN;
        end
      end
      WDG_WAIT: begin
        if (wake_i) begin
          st_d.mode = WDG_RUN;
        end
      end
      WDG_RUN: begin
        if (stop_req_i) begin
          if (!active) begin
            st_d.mode = WDG_STOP;
          end else if (ext_stop_opt_i && nmi_pin_i) begin
            st_d.mode = WDG_STOP;
          end else begin
            st_d.mode = WDG_WAIT;
          end
        end
      end
    endcase
    // reload restarts the countdown; a step decrements
    if (wr && st_q.mode != WDG_RST_HOLD) begin
      st_d.cnt = wr_cnt;
      st_d.ctrl_c = st_q.ctrl_c || wr_data[WDG_C_BIT];
    end else if (tick) begin
      st_d.cnt = dec_cnt;
    end
    // internal reset loads counter and control bit with their system reset values
    if (trig) begin
      st_d.mode = WDG_RST_HOLD;
      st_d.hold = '0;
      st_d.cnt = WDG_CNT_RST;
      st_d.ctrl_c = WDG_CTRL_RST[WDG_C_BIT];
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q.cnt <= WDG_CNT_RST;
      st_q.ctrl_c <= WDG_CTRL_RST[WDG_C_BIT];
      st_q.mode <= WDG_RUN;
      st_q.hold <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs decoded from the registered state; wdg_active_o also from the hardware strap
  assign chip_reset_o = st_q.mode == WDG_RST_HOLD;
  assign reset_pin_o = 1'b0;
  assign reset_pin_oe_o = chip_reset_o;
  assign wait_mode_o = st_q.mode == WDG_WAIT;
  assign stop_mode_o = st_q.mode == WDG_STOP;
  assign wdg_active_o = active;

  // checks on the block's own behaviour
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  sr_clear_reset_a: assert property (
    wr && run && st_q.cnt[6] && !wr_data[WDG_SR_BIT] |=> chip_reset_o
  ) else $error("sr cleared without reset");

  timeout_reset_a: assert property (
    !wr && tick && active && st_q.cnt == 7'h40 |=> chip_reset_o
  ) else $error("end of count without reset");

  timer_no_reset_a: assert property (
    !wr && tick && !active && st_q.cnt == 7'h40
    |=> !chip_reset_o && st_q.cnt == 7'h3f
  ) else $error("inactive timer caused reset");

  active_sticky_a: assert property (
    active && !trig && hw_activation_opt_i == $past(hw_activation_opt_i)
    |=> active
  ) else $error("watchdog deactivated by write");

  inactive_stays_a: assert property (
    !st_q.ctrl_c && !(wr && wr_data[WDG_C_BIT]) |=> !st_q.ctrl_c
  ) else $error("activation without write");

  hw_bit_one_a: assert property (
    hw_activation_opt_i |-> rd_val[WDG_C_BIT]
  ) else $error("activation bit not one");

  reload_map_a: assert property (
    wr && !trig && st_q.mode != WDG_RST_HOLD
    |=> rd_val[7:1] == $past(wr_data[7:1])
  ) else $error("reload value not read back");

  nmi_low_wait_a: assert property (
    st_q.mode == WDG_RUN && stop_req_i && active && ext_stop_opt_i &&
    !nmi_pin_i && !trig |=> wait_mode_o
  ) else $error("stop with nmi low not wait");

  nmi_high_stop_a: assert property (
    st_q.mode == WDG_RUN && stop_req_i && active && ext_stop_opt_i &&
    nmi_pin_i && !trig |=> stop_mode_o
  ) else $error("stop with nmi high not stop");

  hw_stop_wait_a: assert property (
    st_q.mode == WDG_RUN && stop_req_i && hw_activation_opt_i &&
    !ext_stop_opt_i && !trig |=> wait_mode_o ##1 !stop_mode_o
  ) else $error("hardware option entered stop");

  inactive_stop_a: assert property (
    st_q.mode == WDG_RUN && stop_req_i && !active && !trig |=> stop_mode_o
  ) else $error("inactive stop refused");

  stop_freeze_a: assert property (
    stop_mode_o && !wr |=> $stable(st_q.cnt)
  ) else $error("counter moved in stop");

  stop_resume_a: assert property (
    stop_mode_o && wake_i |=> !stop_mode_o && $stable(st_q.cnt)
  ) else $error("stop exit lost count");

  stab_hold_a: assert property (
    $rose(chip_reset_o) |-> chip_reset_o[*8]
  ) else $error("reset shorter than delay");

  reset_pin_a: assert property (
    chip_reset_o |-> reset_pin_oe_o && !reset_pin_o
  ) else $error("reset pin not driven low");

  reset_value_a: assert property (
    $fell(chip_reset_o) |-> rd_val[7:1] == WDG_CTRL_RST[7:1]
  ) else $error("register not at reset value");

  // the counter moves only on a step, a reload or an internal reset;
  // these catch a prescaler that leaks steps into stop or the hold
  cnt_still_a: assert property (
    !tick && !wr && !trig |=> $stable(st_q.cnt)
  ) else $error("counter moved without step");

  wait_count_a: assert property (
    wait_mode_o && tick && !wr && !trig
    |=> st_q.cnt == $past(st_q.cnt) - 7'h1
  ) else $error("counter idle in wait");

  stop_no_step_a: assert property (
    stop_mode_o |-> !tick
  ) else $error("step during stop");

  hold_no_step_a: assert property (
    chip_reset_o |-> !tick && !trig
  ) else $error("step during reset hold");

  hold_write_a: assert property (
    chip_reset_o |=> st_q.cnt == WDG_CNT_RST && !st_q.ctrl_c
  ) else $error("register changed during hold");

  trig_init_a: assert property (
    trig |=> chip_reset_o && st_q.cnt == WDG_CNT_RST && !st_q.ctrl_c
  ) else $error("reset did not reinitialise");

  sr_kept_a: assert property (
    wr && run && wr_data[WDG_SR_BIT] |=> !chip_reset_o
  ) else $error("reload with sr set caused reset");

  timer_wrap_a: assert property (
    !wr && tick && !active && st_q.cnt == 7'h00
    |=> !chip_reset_o && st_q.cnt == WDG_CNT_RST
  ) else $error("free timer did not wrap");

  inactive_quiet_a: assert property (
    !active && !wr |=> !chip_reset_o || $past(chip_reset_o)
  ) else $error("inactive counter caused reset");

  hw_active_a: assert property (
    hw_activation_opt_i |-> wdg_active_o
  ) else $error("hardware option inactive");

  wake_wait_a: assert property (
    wait_mode_o && wake_i && !trig |=> !wait_mode_o && !stop_mode_o
  ) else $error("interrupt did not end wait");

  stop_cause_a: assert property (
    $rose(stop_mode_o) |-> $past(stop_req_i) && $past(run)
  ) else $error("stop without instruction");

  pin_idle_a: assert property (
    !chip_reset_o |-> !reset_pin_oe_o
  ) else $error("reset pin driven outside reset");

  hold_exit_a: assert property (
    $fell(chip_reset_o) |-> !wait_mode_o && !stop_mode_o
  ) else $error("hold did not end in run");

  cov_hold_end_c: cover property ($fell(chip_reset_o));
  cov_timeout_c: cover property (trig_tmo);
  cov_sr_reset_c: cover property (trig_sr);
  cov_stop_wake_c: cover property (stop_mode_o ##1 !stop_mode_o);
  cov_wait_c: cover property (wait_mode_o && tick);

endmodule : wdg_top

// ### dv/wdg_core_model.sv
module wdg_core_model import wdg_pkg::*; (
  // clock
  input wire logic ref_clk_i,
  // bus answer from the block
  input wire wdg_axil_rsp_t rsp_i,
  // bus request and core events
  output wdg_axil_req_t req_o,
  output logic stop_req_o,
  output logic wake_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus and quiet core at time zero
  initial begin
    req_o = '0;
    stop_req_o = 1'b0;
    wake_o = 1'b0;
  end

  // one write, halves dropped as each is taken; reloads the counter only at the control register with byte 0 strobed
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    int i;
    r = 2'bxx;
    @(posedge ref_clk_i);
    req_o.awvalid <= 1'b1;
    req_o.awaddr <= a;
    req_o.wvalid <= 1'b1;
    req_o.wdata <= d;
    req_o.wstrb <= s;
    req_o.bready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge ref_clk_i);
      if (req_o.awvalid && rsp_i.awready) req_o.awvalid <= 1'b0;
      if (req_o.wvalid && rsp_i.wready) req_o.wvalid <= 1'b0;
      if (rsp_i.bvalid) begin
        r = rsp_i.bresp;
        break;
      end
    end
    req_o.bready <= 1'b0;
  endtask : wr

  // one read; a lost answer leaves x, which never matches
  task automatic rd(input logic [31:0] a, output logic [7:0] d,
                    output logic [1:0] r);
    int i;
    r = 2'bxx;
    d = 8'hxx;
    @(posedge ref_clk_i);
    req_o.arvalid <= 1'b1;
    req_o.araddr <= a;
    req_o.rready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge ref_clk_i);
      if (req_o.arvalid && rsp_i.arready) req_o.arvalid <= 1'b0;
      if (rsp_i.rvalid) begin
        d = rsp_i.rdata[7:0];
        r = rsp_i.rresp;
        break;
      end
    end
    req_o.rready <= 1'b0;
  endtask : rd

  // one-cycle stop instruction or interrupt
  task automatic ev(input logic s);
    @(posedge ref_clk_i);
    if (s) stop_req_o <= 1'b1;
    else wake_o <= 1'b1;
    @(posedge ref_clk_i);
    stop_req_o <= 1'b0;
    wake_o <= 1'b0;
  endtask : ev
endmodule : wdg_core_model

// ### dv/wdg_top_tb.sv
module wdg_top_tb import wdg_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic nrst, hw, ext, nmi;
  wdg_axil_req_t req;
  wdg_axil_rsp_t rsp;
  logic stp, wak, wt, sm, act, crst, pin, oe;
  logic [7:0] d, d2;
  logic [1:0] r;
  int n_mismatch = 0;
  int compares = 0;
  int n;

  // short counts keep the run brief
  wdg_top #(.STEP_CYC(16), .STAB_CYC(16)) dut_u (
    .ref_clk_i(clk), .nrst_i(nrst), .axil_req_i(req), .axil_rsp_o(rsp),
    .hw_activation_opt_i(hw), .ext_stop_opt_i(ext), .nmi_pin_i(nmi),
    .stop_req_i(stp), .wake_i(wak), .wait_mode_o(wt), .stop_mode_o(sm),
    .wdg_active_o(act), .chip_reset_o(crst), .reset_pin_o(pin),
    .reset_pin_oe_o(oe));

  wdg_core_model core_u (.ref_clk_i(clk), .rsp_i(rsp), .req_o(req),
    .stop_req_o(stp), .wake_o(wak));

  // 200 mhz
  always #2.5 clk = ~clk;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic results;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  // a lost bus answer leaves x: count it and end the run
  task automatic bus_chk(input logic [1:0] er);
    chk(r, er);
    if ($isunknown(r)) results();
  endtask : bus_chk

  // straps change only under reset
  task automatic rst(input logic h, input logic e);
    @(posedge clk);
    hw <= h;
    ext <= e;
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
  endtask : rst

  task automatic wr(input logic [7:0] v, input logic [1:0] er);
    core_u.wr(WDG_CTRL_OFS, {24'h0, v}, 4'hf, r);
    bus_chk(er);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [7:0] e,
                    input logic [1:0] er);
    logic [7:0] g;
    core_u.rd(a, g, r);
    chk(g, e);
    bus_chk(er);
  endtask : rd

  // wait for the chip reset within a window, then time its hold
  task automatic to_rst(input int lo, input int hi);
    n = 0;
    while (crst !== 1'b1 && n <= hi) begin
      @(posedge clk);
      n++;
    end
    chk(n >= lo && n <= hi, 1);
    if (n > hi) begin
      results();
    end else begin
      chk({pin, oe}, 2'b01);
      n = 0;
      while (crst === 1'b1 && n < 99) begin
        @(posedge clk);
        n++;
      end
      chk(n, 16);
    end
  endtask : to_rst

  // stop instruction, then look at the mode one cycle later
  task automatic stop_chk(input logic [1:0] e);
    core_u.ev(1'b1);
    @(posedge clk);
    chk({wt, sm}, e);
  endtask : stop_chk

  initial begin
    nrst = 1'b0;
    hw = 1'b0;
    ext = 1'b0;
    nmi = 1'b0;
    rst(1'b0, 1'b0);
    rd(WDG_CTRL_OFS, WDG_CTRL_RST, WDG_RESP_OKAY);
    chk(act, 0);
    rd(32'h0, 8'h00, WDG_RESP_SLVERR);
    // unmapped or unstrobed writes of sr zero must not reach the register
    core_u.wr(32'h0, 32'h0, 4'hf, r);
    bus_chk(WDG_RESP_SLVERR);
    chk(crst, 0);
    core_u.wr(WDG_CTRL_OFS, 32'hffff_ff00, 4'he, r);
    bus_chk(WDG_RESP_OKAY);
    chk(crst, 0);
    // inactive counter wraps freely, no reset
    n = 0;
    repeat (2100) begin
      @(posedge clk);
      if (crst !== 1'b0) n++;
    end
    chk(n, 0);
    stop_chk(2'b01);
    core_u.ev(1'b0);
    @(posedge clk);
    chk({wt, sm}, 2'b00);
    wr(8'h83, WDG_RESP_OKAY);
    chk(act, 1);
    wr(8'h82, WDG_RESP_OKAY);
    rd(WDG_CTRL_OFS, 8'h83, WDG_RESP_OKAY);
    // a reload midway restarts the whole period
    repeat (20) @(posedge clk);
    wr(8'h83, WDG_RESP_OKAY);
    to_rst(29, 35);
    rd(WDG_CTRL_OFS, WDG_CTRL_RST, WDG_RESP_OKAY);
    chk(act, 0);
    wr(8'h00, WDG_RESP_OKAY);
    to_rst(0, 3);
    // hardware option with nmi gating
    nmi <= 1'b1;
    rst(1'b1, 1'b1);
    rd(WDG_CTRL_OFS, 8'hff, WDG_RESP_OKAY);
    wr(8'hfe, WDG_RESP_OKAY);
    rd(WDG_CTRL_OFS, 8'hff, WDG_RESP_OKAY);
    stop_chk(2'b01);
    core_u.rd(WDG_CTRL_OFS, d, r);
    bus_chk(WDG_RESP_OKAY);
    repeat (100) @(posedge clk);
    rd(WDG_CTRL_OFS, d, WDG_RESP_OKAY);
    core_u.ev(1'b0);
    repeat (40) @(posedge clk);
    core_u.rd(WDG_CTRL_OFS, d2, r);
    bus_chk(WDG_RESP_OKAY);
    chk(d2 !== d, 1);
    nmi <= 1'b0;
    stop_chk(2'b10);
    core_u.ev(1'b0);
    // hardware option alone: stop acts as wait and counting goes on
    rst(1'b1, 1'b0);
    wr(8'h03, WDG_RESP_OKAY);
    stop_chk(2'b10);
    to_rst(8, 20);
    results();
  end
endmodule : wdg_top_tb
